// ==== core/tcx_ext_irq_det.sv ====
// tcx_ext_irq_det: edge or level detector and flag for one external interrupt input
`timescale 1ns/1ps
`default_nettype none

module tcx_ext_irq_det (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic irq_in,
  input  wire logic polarity,
  input  wire logic type_sel,
  input  wire logic vector_ack,
  input  wire logic sw_wr,
  input  wire logic sw_val,
  output logic      flag_ff
);

  logic active;
  logic prev_active_ff;
  logic event_now;
  logic nxt_flag;

  // active sense comes from the polarity input only, never from type_sel
  assign active = irq_in ~^ polarity;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      prev_active_ff <= 1'b0;
    else if (ce)
      prev_active_ff <= active;
  end

  // ----------------------------------------------------------------
  // flag update: a detected event beats any clear in the same cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    event_now = (type_sel == tcx_pkg::TYPE_EDGE) ? (active & ~prev_active_ff) : active;
    // level mode keeps no memory: the flag is rebuilt each cycle from the input and any software write
    nxt_flag  = (type_sel == tcx_pkg::TYPE_EDGE) ? flag_ff : 1'b0;
    if (sw_wr)
      nxt_flag = sw_val;
    else if (vector_ack && type_sel == tcx_pkg::TYPE_EDGE)
      nxt_flag = 1'b0;
    if (event_now)
      nxt_flag = 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      flag_ff <= tcx_pkg::RST_FLAG;
    else if (ce)
      flag_ff <= nxt_flag;
  end

endmodule
`default_nettype wire

// ==== core/tcx_pkg.sv ====
// tcx_pkg: addresses, field positions and reset values of the timer control slice
package tcx_pkg;

  // ----------------------------------------------------------------
  // special-function addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_CTL   = 8'h88;
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] PAGE_RELOAD      = 8'h00;

  // ----------------------------------------------------------------
  // timer control field positions
  // ----------------------------------------------------------------
  localparam int BIT_TIMER0_RUN     = 4;
  localparam int BIT_EXT_B_FLAG     = 3;
  localparam int BIT_EXT_B_TYPE_SEL = 2;
  localparam int BIT_EXT_A_FLAG     = 1;
  localparam int BIT_EXT_A_TYPE_SEL = 0;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RELOAD_LOW  = 8'h00;
  localparam logic [7:0] RST_RELOAD_HIGH = 8'h00;
  localparam logic       RST_TIMER0_RUN  = 1'b0;
  localparam logic       RST_TYPE_SEL    = 1'b0;
  localparam logic       RST_FLAG        = 1'b0;
  localparam logic [7:0] RST_READ_DATA   = 8'h00;
  localparam logic       TYPE_LEVEL      = 1'b0;
  localparam logic       TYPE_EDGE       = 1'b1;

endpackage

// ==== core/tcx_timer_ctl.sv ====
// tcx_timer_ctl: timer 0 run control, external interrupt flags and timer 2 reload bytes
`timescale 1ns/1ps
`default_nettype none

module tcx_timer_ctl (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_page,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       ext_irq_a_input,
  input  wire logic       ext_irq_b_input,
  input  wire logic       ext_irq_a_polarity,
  input  wire logic       ext_irq_b_polarity,
  input  wire logic       ext_irq_a_vector_ack,
  input  wire logic       ext_irq_b_vector_ack,
  output logic [7:0]      sfr_rdata_ff,
  output logic            sfr_rhit_ff,
  output logic            timer0_run_ctl,
  output logic            ext_irq_a_flag,
  output logic            ext_irq_b_flag,
  output logic            ext_irq_a_type_sel,
  output logic            ext_irq_b_type_sel,
  output logic [7:0]      timer2_reload_low_byte,
  output logic [7:0]      timer2_reload_high_byte
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit_reload(input logic [7:0] addr, input logic [7:0] page,
                                      input logic [7:0] target);
    hit_reload = (addr == target) && (page == tcx_pkg::PAGE_RELOAD);
  endfunction

  logic sel_ctl;
  logic sel_low;
  logic sel_high;
  logic ctl_wr;

  // control register is visible on every page
  assign sel_ctl  = (sfr_addr == tcx_pkg::ADDR_TIMER_CTL);
  assign sel_low  = hit_reload(sfr_addr, sfr_page, tcx_pkg::ADDR_RELOAD_LOW);
  assign sel_high = hit_reload(sfr_addr, sfr_page, tcx_pkg::ADDR_RELOAD_HIGH);
  assign ctl_wr   = sfr_wr && sel_ctl;

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      timer0_run_ctl <= tcx_pkg::RST_TIMER0_RUN;
    else if (ce && ctl_wr)
      timer0_run_ctl <= sfr_wdata[tcx_pkg::BIT_TIMER0_RUN];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_irq_a_type_sel <= tcx_pkg::RST_TYPE_SEL;
      ext_irq_b_type_sel <= tcx_pkg::RST_TYPE_SEL;
    end
    else if (ce && ctl_wr)
    begin
      ext_irq_a_type_sel <= sfr_wdata[tcx_pkg::BIT_EXT_A_TYPE_SEL];
      ext_irq_b_type_sel <= sfr_wdata[tcx_pkg::BIT_EXT_B_TYPE_SEL];
    end
  end

  // ----------------------------------------------------------------
  // external interrupt detectors
  // ----------------------------------------------------------------
  // level mode rebuilds the flag each cycle from the active level or a software write, so a
  // software clear only sticks once the input has gone inactive
  tcx_ext_irq_det u_det_a (
    .core_clk   (core_clk),
    .rst        (rst),
    .ce         (ce),
    .irq_in     (ext_irq_a_input),
    .polarity   (ext_irq_a_polarity),
    .type_sel   (ext_irq_a_type_sel),
    .vector_ack (ext_irq_a_vector_ack),
    .sw_wr      (ctl_wr),
    .sw_val     (sfr_wdata[tcx_pkg::BIT_EXT_A_FLAG]),
    .flag_ff    (ext_irq_a_flag)
  );

  tcx_ext_irq_det u_det_b (
    .core_clk   (core_clk),
    .rst        (rst),
    .ce         (ce),
    .irq_in     (ext_irq_b_input),
    .polarity   (ext_irq_b_polarity),
    .type_sel   (ext_irq_b_type_sel),
    .vector_ack (ext_irq_b_vector_ack),
    .sw_wr      (ctl_wr),
    .sw_val     (sfr_wdata[tcx_pkg::BIT_EXT_B_FLAG]),
    .flag_ff    (ext_irq_b_flag)
  );

  // ----------------------------------------------------------------
  // timer 2 reload bytes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      timer2_reload_low_byte <= tcx_pkg::RST_RELOAD_LOW;
    else if (ce && sfr_wr && sel_low)
      timer2_reload_low_byte <= sfr_wdata;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      timer2_reload_high_byte <= tcx_pkg::RST_RELOAD_HIGH;
    else if (ce && sfr_wr && sel_high)
      timer2_reload_high_byte <= sfr_wdata;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // bits 7:5 of the control register belong to the timer 1 / overflow
  // logic elsewhere; this slice returns zero there and the core ors the
  // answers of all slices that raise a hit
  logic [7:0] ctl_view;
  logic [7:0] nxt_rdata;
  logic       nxt_rhit;

  always_comb
  begin
    ctl_view = 8'h00;
    ctl_view[tcx_pkg::BIT_TIMER0_RUN]     = timer0_run_ctl;
    ctl_view[tcx_pkg::BIT_EXT_B_FLAG]     = ext_irq_b_flag;
    ctl_view[tcx_pkg::BIT_EXT_B_TYPE_SEL] = ext_irq_b_type_sel;
    ctl_view[tcx_pkg::BIT_EXT_A_FLAG]     = ext_irq_a_flag;
    ctl_view[tcx_pkg::BIT_EXT_A_TYPE_SEL] = ext_irq_a_type_sel;
    nxt_rdata = tcx_pkg::RST_READ_DATA;
    nxt_rhit  = 1'b0;
    if (sfr_rd)
    begin
      if (sel_ctl)
      begin
        nxt_rdata = ctl_view;
        nxt_rhit  = 1'b1;
      end
      else if (sel_low)
      begin
        nxt_rdata = timer2_reload_low_byte;
        nxt_rhit  = 1'b1;
      end
      else if (sel_high)
      begin
        nxt_rdata = timer2_reload_high_byte;
        nxt_rhit  = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sfr_rdata_ff <= tcx_pkg::RST_READ_DATA;
      sfr_rhit_ff  <= 1'b0;
    end
    else if (ce)
    begin
      sfr_rdata_ff <= nxt_rdata;
      sfr_rhit_ff  <= nxt_rhit;
    end
  end

endmodule
`default_nettype wire

// ==== dv/tcx_timer_ctl_checker.sv ====
// tcx_timer_ctl_checker: concurrent checks on the timer control slice ports
`timescale 1ns/1ps
`default_nettype none

module tcx_timer_ctl_checker (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic       ext_irq_a_input,
  input wire logic       ext_irq_a_polarity,
  input wire logic       ext_irq_a_vector_ack,
  input wire logic [7:0] sfr_rdata_ff,
  input wire logic       sfr_rhit_ff,
  input wire logic       timer0_run_ctl,
  input wire logic       ext_irq_a_flag,
  input wire logic       ext_irq_a_type_sel,
  input wire logic [7:0] timer2_reload_low_byte,
  input wire logic [7:0] timer2_reload_high_byte
);
  wire logic act_a  = ext_irq_a_input ~^ ext_irq_a_polarity;
  wire logic wr_ctl = ce && sfr_wr && sfr_addr == tcx_pkg::ADDR_TIMER_CTL;
  wire logic pg0    = ce && sfr_page == tcx_pkg::PAGE_RELOAD;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // edge detection: an inactive sample, then an active one, undisturbed
  // ----------------------------------------------------------------
  sequence s_quiet_rise;
    ce && ext_irq_a_type_sel && !act_a && !ext_irq_a_vector_ack
    ##1 ce && ext_irq_a_type_sel && act_a && !sfr_wr && !ext_irq_a_vector_ack;
  endsequence

  a_run_write: assert property (wr_ctl |=> timer0_run_ctl == $past(sfr_wdata[tcx_pkg::BIT_TIMER0_RUN]))
    else $error("run control does not follow write");
  a_type_write: assert property (wr_ctl
    |=> ext_irq_a_type_sel == $past(sfr_wdata[tcx_pkg::BIT_EXT_A_TYPE_SEL]))
    else $error("type select does not follow write");
  a_level_active: assert property (ce && !ext_irq_a_type_sel && act_a && !sfr_wr
    |=> ext_irq_a_flag) else $error("level flag missed");
  a_level_idle: assert property (ce && !ext_irq_a_type_sel && !act_a && !sfr_wr
    |=> !ext_irq_a_flag) else $error("level flag with inactive input");
  a_low_write: assert property (pg0 && sfr_wr && sfr_addr == tcx_pkg::ADDR_RELOAD_LOW
    |=> timer2_reload_low_byte == $past(sfr_wdata)) else $error("low byte write");
  a_high_write: assert property (pg0 && sfr_wr && sfr_addr == tcx_pkg::ADDR_RELOAD_HIGH
    |=> timer2_reload_high_byte == $past(sfr_wdata)) else $error("high byte write");
  a_page_refuse: assert property (ce && sfr_wr && sfr_page != tcx_pkg::PAGE_RELOAD
    |=> $stable(timer2_reload_low_byte) && $stable(timer2_reload_high_byte))
    else $error("reload written off page zero");
  a_read_high: assert property (pg0 && sfr_rd && sfr_addr == tcx_pkg::ADDR_RELOAD_HIGH
    |=> sfr_rhit_ff && sfr_rdata_ff == $past(timer2_reload_high_byte))
    else $error("high byte read");
  a_edge_set: assert property (s_quiet_rise |=> ext_irq_a_flag)
    else $error("edge flag not set");
  a_edge_ack: assert property (ce && ext_irq_a_type_sel && ext_irq_a_vector_ack && !act_a
    && !sfr_wr |=> !ext_irq_a_flag) else $error("ack did not clear flag");
endmodule

`default_nettype wire

// ==== dv/test_tcx_timer_ctl.sv ====
// test_tcx_timer_ctl: directed scenarios for the timer control slice
`timescale 1ns/1ps
`default_nettype none

module test_tcx_timer_ctl;
  logic       core_clk, rst, ce, sfr_wr, sfr_rd, sfr_rhit_ff, timer0_run_ctl;
  logic       ext_irq_a_input, ext_irq_b_input, ext_irq_a_polarity, ext_irq_b_polarity;
  logic       ext_irq_a_vector_ack, ext_irq_b_vector_ack, ext_irq_a_flag, ext_irq_b_flag;
  logic       ext_irq_a_type_sel, ext_irq_b_type_sel;
  logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata_ff;
  logic [7:0] timer2_reload_low_byte, timer2_reload_high_byte;
  int         fail_count = 0;
  int         comparisons = 0;

  tcx_timer_ctl dut (.*);

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one access per call; returns in the cycle where read data stands
  task automatic acc(input logic w, input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {sfr_wr, sfr_rd, sfr_page, sfr_addr, sfr_wdata} = {w, !w, pg, a, d};
    @(negedge core_clk);
    {sfr_wr, sfr_rd} = 2'b00;
  endtask

  task automatic rd(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] exp, input logic hit);
    acc(1'b0, pg, a, 8'h00);
    check("read data", exp, sfr_rdata_ff);
    check("read hit", 8'(hit), 8'(sfr_rhit_ff));
  endtask

  task automatic t_reload;
    check("low reset", tcx_pkg::RST_RELOAD_LOW, timer2_reload_low_byte);
    check("high reset", tcx_pkg::RST_RELOAD_HIGH, timer2_reload_high_byte);
    acc(1'b1, 8'h00, 8'hca, 8'h5a);
    acc(1'b1, 8'h00, 8'hcb, 8'ha5);
    rd(8'h00, 8'hca, 8'h5a, 1'b1);
    rd(8'h00, 8'hcb, 8'ha5, 1'b1);
    acc(1'b1, 8'h01, 8'hcb, 8'h3c);
    check("high off page", 8'ha5, timer2_reload_high_byte);
    rd(8'h01, 8'hcb, 8'h00, 1'b0);
    rd(8'h00, 8'hcc, 8'h00, 1'b0);
    $display("reload test done");
  endtask

  task automatic t_run;
    acc(1'b1, 8'h03, 8'h88, 8'h10);
    check("run on", 8'h01, 8'(timer0_run_ctl));
    rd(8'h00, 8'h88, 8'h10, 1'b1);
    acc(1'b1, 8'h00, 8'h88, 8'h00);
    check("run off", 8'h00, 8'(timer0_run_ctl));
    $display("run test done");
  endtask

  task automatic t_level;
    @(negedge core_clk);
    ext_irq_a_polarity = 1'b0;
    repeat (2) @(negedge core_clk);
    check("level low active", 8'h01, 8'(ext_irq_a_flag));
    ext_irq_a_input = 1'b1;
    repeat (2) @(negedge core_clk);
    check("level released", 8'h00, 8'(ext_irq_a_flag));
    ext_irq_a_polarity = 1'b1;
    $display("level test done");
  endtask

  task automatic t_edge;
    @(negedge core_clk);
    {ext_irq_a_input, ext_irq_b_input} = 2'b00;
    acc(1'b1, 8'h00, 8'h88, 8'h05);
    // one inactive sample in edge mode first, so the rise is a clean edge
    @(negedge core_clk);
    {ext_irq_a_input, ext_irq_b_input} = 2'b11;
    repeat (2) @(negedge core_clk);
    check("edge flags", 8'h03, {6'h00, ext_irq_b_flag, ext_irq_a_flag});
    {ext_irq_a_input, ext_irq_a_vector_ack} = 2'b01;
    @(negedge core_clk);
    ext_irq_a_vector_ack = 1'b0;
    rd(8'h00, 8'h88, 8'h0d, 1'b1);
    acc(1'b1, 8'h00, 8'h88, 8'h05);
    check("sw clear b", 8'h00, 8'(ext_irq_b_flag));
    $display("edge test done");
  endtask

  task automatic t_freeze;
    ce = 1'b0;
    acc(1'b1, 8'h00, 8'hca, 8'h11);
    check("frozen write", 8'h5a, timer2_reload_low_byte);
    ce = 1'b1;
    $display("freeze test done");
  endtask

  task automatic t_irq_b;
    ext_irq_b_input = 1'b0;
    @(negedge core_clk);
    {ext_irq_b_input, ext_irq_b_vector_ack} = 2'b11;
    @(negedge core_clk);
    check("set beats ack", 8'h01, 8'(ext_irq_b_flag));
    @(negedge core_clk);
    check("ack clears b", 8'h00, 8'(ext_irq_b_flag));
    ext_irq_b_vector_ack = 1'b0;
    acc(1'b1, 8'h00, 8'h88, 8'h0c);
    check("sw set b", 8'h01, 8'(ext_irq_b_flag));
    check("type sel", 8'h02, {6'h00, ext_irq_b_type_sel, ext_irq_a_type_sel});
    ext_irq_b_polarity = 1'b0;
    acc(1'b1, 8'h00, 8'h88, 8'h00);
    check("level b idle", 8'h00, 8'(ext_irq_b_flag));
    ext_irq_b_input = 1'b0;
    repeat (2) @(negedge core_clk);
    check("level b active", 8'h01, 8'(ext_irq_b_flag));
    $display("irq b test done");
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // hang guard
  initial
  begin
    repeat (2000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    {sfr_wr, sfr_rd, sfr_addr, sfr_page, sfr_wdata} = '0;
    {ext_irq_a_input, ext_irq_b_input, ext_irq_a_vector_ack, ext_irq_b_vector_ack} = '0;
    {ext_irq_a_polarity, ext_irq_b_polarity, ce, rst} = 4'hf;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_reload();
    t_run();
    t_level();
    t_edge();
    t_freeze();
    t_irq_b();
    report_and_stop();
  end
endmodule

bind tcx_timer_ctl tcx_timer_ctl_checker chk (.*);

`default_nettype wire
